// ==== logic/regulator_fault_flags_masks.sv ====
// Summary of operation
// RL1 - Overcurrent events set bit 0 (third), bit 1 (second) and bit 2 (first regulator).
// RL2 - Overvoltage events set bit 3 (third), bit 4 (second) and bit 5 (first regulator).
// RL3 - Undervoltage events set bit 6 (third), bit 7 (second) and bit 8 (first regulator).
// RL4 - An open-loop event on the second regulator sets bit 9.
// RL5 - Thermal shutdown sets bit 10 (third), bit 11 (second) and bit 12 (first regulator).
// RL6 - A die temperature warning of the first regulator sets bit 13.
// RL7 - Overvoltage on the external voltage monitor input sets bit 14.
// RL8 - Undervoltage on the external voltage monitor input sets bit 15.
// RL9 - A flag stays set until software writes 1 to its bit, which clears that flag alone.
// RL10 - Power-on reset clears every flag.
// RL11 - Mask bits match flag positions, 1 inhibits and 0 allows, read/write, cleared by reset.
// RL12 - The interrupt is high while any flag is set with its mask bit at 0.
// RL13 - Writing 0 leaves a flag alone and an event coinciding with a clear keeps it set.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module regulator_fault_flags_masks
  import fault_flags_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic third_reg_overcurrent,
  input wire logic second_reg_overcurrent,
  input wire logic first_reg_overcurrent,
  input wire logic third_reg_overvoltage,
  input wire logic second_reg_overvoltage,
  input wire logic first_reg_overvoltage,
  input wire logic third_reg_undervoltage,
  input wire logic second_reg_undervoltage,
  input wire logic first_reg_undervoltage,
  input wire logic second_reg_open_loop,
  input wire logic third_reg_thermal_shutdown,
  input wire logic second_reg_thermal_shutdown,
  input wire logic first_reg_thermal_shutdown,
  input wire logic first_reg_thermal_warning,
  input wire logic ext_monitor_overvoltage,
  input wire logic ext_monitor_undervoltage,
  output logic irq
);
  typedef struct packed {
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] masks;
    logic [DATA_W-1:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
  } ctrl_state_t;

  ctrl_state_t state;
  ctrl_state_t next_state;
  logic [FLAG_W-1:0] raw_events;
  logic [FLAG_W-1:0] sync_events;
  logic [FLAG_W-1:0] event_seen;
  logic [FLAG_W-1:0] event_pulse;

  function automatic logic [FLAG_W-1:0] lane_write(
    input logic [FLAG_W-1:0] old_value,
    input logic [DATA_W-1:0] data,
    input logic [3:0] strobe
  );
    logic [FLAG_W-1:0] result;
    result = old_value;
    if (strobe[0]) begin
      result[7:0] = data[7:0];
    end
    if (strobe[1]) begin
      result[15:8] = data[15:8];
    end
    return result;
  endfunction : lane_write

  // RL1 overcurrent positions
  assign raw_events[THIRD_OC_BIT] = third_reg_overcurrent;
  assign raw_events[SECOND_OC_BIT] = second_reg_overcurrent;
  assign raw_events[FIRST_OC_BIT] = first_reg_overcurrent;
  // RL2 overvoltage positions
  assign raw_events[THIRD_OV_BIT] = third_reg_overvoltage;
  assign raw_events[SECOND_OV_BIT] = second_reg_overvoltage;
  assign raw_events[FIRST_OV_BIT] = first_reg_overvoltage;
  // RL3 undervoltage positions
  assign raw_events[THIRD_UV_BIT] = third_reg_undervoltage;
  assign raw_events[SECOND_UV_BIT] = second_reg_undervoltage;
  assign raw_events[FIRST_UV_BIT] = first_reg_undervoltage;
  // RL4 open loop position
  assign raw_events[SECOND_OL_BIT] = second_reg_open_loop;
  // RL5 shutdown positions
  assign raw_events[THIRD_TSD_BIT] = third_reg_thermal_shutdown;
  assign raw_events[SECOND_TSD_BIT] = second_reg_thermal_shutdown;
  assign raw_events[FIRST_TSD_BIT] = first_reg_thermal_shutdown;
  // RL6 warning position
  assign raw_events[FIRST_TWARN_BIT] = first_reg_thermal_warning;
  // RL7 monitor overvoltage
  assign raw_events[EXT_OV_BIT] = ext_monitor_overvoltage;
  // RL8 monitor undervoltage
  assign raw_events[EXT_UV_BIT] = ext_monitor_undervoltage;

  // detectors are analog, so synchronise first
  event_sync #(
    .WIDTH(FLAG_W)
  ) u_event_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in(raw_events),
    .sync_out(sync_events)
  );

  // level-sensitive: a persisting fault re-sets the flag after a clear
  assign event_seen = sync_events;

  logic apb_access;
  logic apb_write;
  logic flags_hit;
  logic masks_hit;
  logic [FLAG_W-1:0] clear_bits;

  always_comb begin
    apb_access = psel && penable && !state.ready;
    apb_write = apb_access && pwrite;
    flags_hit = paddr == FLAGS_OFFSET;
    masks_hit = paddr == MASKS_OFFSET;
    clear_bits = '0;
    if (apb_write && flags_hit) begin
      clear_bits = lane_write('0, pwdata, pstrb);
    end
  end

  assign event_pulse = event_seen;

  always_comb begin
    next_state = state;
    next_state.ready = apb_access;
    next_state.slverr = apb_access && !(flags_hit || masks_hit);
    next_state.rdata = '0;
    // RL9 write one clears
    // RL13 set wins over clear
    next_state.flags = (state.flags & ~clear_bits) | event_pulse;
    if (apb_write && masks_hit) begin
      // RL11 mask read write
      next_state.masks = lane_write(state.masks, pwdata, pstrb);
    end
    if (apb_access && !pwrite) begin
      if (flags_hit) begin
        next_state.rdata = {{(DATA_W-FLAG_W){1'b0}}, state.flags};
      end else if (masks_hit) begin
        next_state.rdata = {{(DATA_W-FLAG_W){1'b0}}, state.masks};
      end
    end
    // RL12 unmasked flag drives irq
    next_state.irq = |(next_state.flags & ~next_state.masks);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      // RL10 flags cleared by reset
      state.flags <= FLAGS_RESET;
      state.masks <= MASKS_RESET;
      state.rdata <= '0;
      state.ready <= 1'b0;
      state.slverr <= 1'b0;
      state.irq <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign prdata = state.rdata;
  assign pready = state.ready;
  assign pslverr = state.slverr;
  assign irq = state.irq;

  // assertions
  logic [FLAG_W-1:0] race_bits;
  assign race_bits = clear_bits & sync_events;

  sequence s_first_oc_held;
    $rose(raw_events[FIRST_OC_BIT]) ##0 raw_events[FIRST_OC_BIT] [*2];
  endsequence

  sequence s_access_wait;
    psel && penable && !pready;
  endsequence

  sequence s_ready_pulse;
    pready ##1 !pready;
  endsequence

  property p_flag_sticky;
    @(posedge clock) disable iff (sys_rst)
      (state.flags[0] && !clear_bits[0]) |=> state.flags[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear"); // RL9

  // two input flops, then the flag flop
  property p_event_sets;
    @(posedge clock) disable iff (sys_rst)
      s_first_oc_held |-> ##2 state.flags[FIRST_OC_BIT];
  endproperty
  a_event_sets: assert property (p_event_sets) else $error("overcurrent flag not set"); // RL1

  property p_event_map(int idx);
    @(posedge clock) disable iff (sys_rst)
      raw_events[idx] [*2] |-> ##2 state.flags[idx];
  endproperty

  // every flag position
  for (genvar i = 0; i < FLAG_W; i++) begin : g_event_map
    a_event_map: assert property (p_event_map(i)) else $error("event missed its flag"); // RL2 RL3 RL4 RL5 RL6 RL7
  end

  property p_ext_uv_sets;
    @(posedge clock) disable iff (sys_rst)
      sync_events[EXT_UV_BIT] |=> state.flags[EXT_UV_BIT];
  endproperty
  a_ext_uv_sets: assert property (p_ext_uv_sets) else $error("monitor undervoltage flag not set"); // RL8

  property p_set_wins;
    @(posedge clock) disable iff (sys_rst)
      (race_bits != '0) |=> ((state.flags & $past(race_bits)) == $past(race_bits));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost under clear"); // RL13

  property p_clear_works;
    @(posedge clock) disable iff (sys_rst)
      (clear_bits[SECOND_OL_BIT] && !sync_events[SECOND_OL_BIT]) |=> !state.flags[SECOND_OL_BIT];
  endproperty
  a_clear_works: assert property (p_clear_works) else $error("write one did not clear"); // RL9

  property p_irq_follows;
    @(posedge clock) disable iff (sys_rst)
      (((sync_events & ~state.masks) != '0) && !(apb_write && masks_hit)) |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq disagrees with flags and masks"); // RL12

  // masked flags, however many, stay quiet
  property p_irq_inhibit;
    @(posedge clock) disable iff (sys_rst)
      ((((state.flags | sync_events) & ~state.masks) == '0) && !(apb_write && masks_hit)) |=> !irq;
  endproperty
  a_irq_inhibit: assert property (p_irq_inhibit) else $error("masked flag raised irq"); // RL11

  property p_mask_write;
    @(posedge clock) disable iff (sys_rst)
      (apb_write && masks_hit && pstrb == 4'hF) |=> (state.masks == $past(pwdata[15:0]));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost"); // RL11

  property p_zero_write_keeps;
    @(posedge clock) disable iff (sys_rst)
      (apb_write && flags_hit && pwdata[15:0] == 16'h0000) |=> (state.flags & $past(state.flags)) == $past(state.flags);
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("zero write changed a flag"); // RL13

  property p_ready_one_cycle;
    @(posedge clock) disable iff (sys_rst)
      s_access_wait |=> s_ready_pulse;
  endproperty
  a_ready_one_cycle: assert property (p_ready_one_cycle) else $error("pready not a single pulse"); // APB handshake, the design's own

  property p_clear_only_one;
    @(posedge clock) disable iff (sys_rst)
      (apb_write && flags_hit && sync_events == '0) |=> (state.flags == ($past(state.flags) & ~$past(clear_bits)));
  endproperty
  a_clear_only_one: assert property (p_clear_only_one) else $error("clear touched other flags"); // RL9

  property p_stray_keeps;
    @(posedge clock) disable iff (sys_rst)
      (apb_write && !flags_hit && !masks_hit && sync_events == '0) |=> (state.flags == $past(state.flags));
  endproperty
  a_stray_keeps: assert property (p_stray_keeps) else $error("stray write changed flags"); // RL9

  property p_flags_read;
    @(posedge clock) disable iff (sys_rst)
      (apb_access && !pwrite && flags_hit) |=> (prdata[DATA_W-1:FLAG_W] == '0 && prdata[FLAG_W-1:0] == $past(state.flags));
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flag read data wrong"); // RL9

  property p_masks_read;
    @(posedge clock) disable iff (sys_rst)
      (apb_access && !pwrite && masks_hit) |=> (prdata[DATA_W-1:FLAG_W] == '0 && prdata[FLAG_W-1:0] == $past(state.masks));
  endproperty
  a_masks_read: assert property (p_masks_read) else $error("mask read data wrong"); // RL11

  // unmapped: write dropped, read zero, error flagged
  property p_stray_refused;
    @(posedge clock) disable iff (sys_rst)
      (apb_access && !flags_hit && !masks_hit) |=> (pslverr && pready && prdata == '0 && $stable(state.masks));
  endproperty
  a_stray_refused: assert property (p_stray_refused) else $error("unmapped access not refused"); // RL11

  // no disable here: reset itself is the subject
  property p_reset_clears;
    @(posedge clock)
      sys_rst |=> (state.flags == FLAGS_RESET && state.masks == MASKS_RESET && !irq);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset left state behind"); // RL10
endmodule : regulator_fault_flags_masks

// ==== logic/fault_flags_pkg.sv ====
package fault_flags_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FLAG_W = 16;
  localparam int unsigned ADDR_W = 12;
  // register byte offsets
  localparam logic [11:0] FLAGS_OFFSET = 12'h000;
  localparam logic [11:0] MASKS_OFFSET = 12'h004;
  // flag positions
  localparam int unsigned THIRD_OC_BIT = 0;
  localparam int unsigned SECOND_OC_BIT = 1;
  localparam int unsigned FIRST_OC_BIT = 2;
  localparam int unsigned THIRD_OV_BIT = 3;
  localparam int unsigned SECOND_OV_BIT = 4;
  localparam int unsigned FIRST_OV_BIT = 5;
  localparam int unsigned THIRD_UV_BIT = 6;
  localparam int unsigned SECOND_UV_BIT = 7;
  localparam int unsigned FIRST_UV_BIT = 8;
  localparam int unsigned SECOND_OL_BIT = 9;
  localparam int unsigned THIRD_TSD_BIT = 10;
  localparam int unsigned SECOND_TSD_BIT = 11;
  localparam int unsigned FIRST_TSD_BIT = 12;
  localparam int unsigned FIRST_TWARN_BIT = 13;
  localparam int unsigned EXT_OV_BIT = 14;
  localparam int unsigned EXT_UV_BIT = 15;
  // reset values
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] MASKS_RESET = 16'h0000;
endpackage : fault_flags_pkg

// ==== logic/event_sync.sv ====
`timescale 1ns/10ps
module event_sync
  import fault_flags_pkg::*;
#(
  parameter int unsigned WIDTH = FLAG_W
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // first stage read only by second stage
  always_comb begin
    next_state.first = async_in;
    next_state.second = state.first;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.second;
endmodule : event_sync

// ==== tb/regulator_fault_flags_masks_tb.sv ====
`timescale 1ns/10ps
module regulator_fault_flags_masks_tb
  import fault_flags_pkg::*;
;
  logic clock;
  logic sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [3:0] pstrb;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [FLAG_W-1:0] ev;
  logic [DATA_W-1:0] rd;
  logic err;
  logic [3:0] strb;
  int fail_count;
  int n_tests;

  regulator_fault_flags_masks i_dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .third_reg_overcurrent(ev[THIRD_OC_BIT]), .second_reg_overcurrent(ev[SECOND_OC_BIT]),
    .first_reg_overcurrent(ev[FIRST_OC_BIT]), .third_reg_overvoltage(ev[THIRD_OV_BIT]),
    .second_reg_overvoltage(ev[SECOND_OV_BIT]), .first_reg_overvoltage(ev[FIRST_OV_BIT]),
    .third_reg_undervoltage(ev[THIRD_UV_BIT]), .second_reg_undervoltage(ev[SECOND_UV_BIT]),
    .first_reg_undervoltage(ev[FIRST_UV_BIT]), .second_reg_open_loop(ev[SECOND_OL_BIT]),
    .third_reg_thermal_shutdown(ev[THIRD_TSD_BIT]), .second_reg_thermal_shutdown(ev[SECOND_TSD_BIT]),
    .first_reg_thermal_shutdown(ev[FIRST_TSD_BIT]), .first_reg_thermal_warning(ev[FIRST_TWARN_BIT]),
    .ext_monitor_overvoltage(ev[EXT_OV_BIT]), .ext_monitor_undervoltage(ev[EXT_UV_BIT]), .irq(irq));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // held until pready is seen at a rising edge; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= w ? strb : 4'h0;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // wait to the falling edge so later checks see settled outputs
    @(negedge clock);
  endtask : bus

  task automatic read_reg(input logic [11:0] a, input string what, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check_word(what, exp, rd);
  endtask : read_reg

  // held two cycles: enough to cross the two input flops
  task automatic pulse(input logic [15:0] v);
    @(posedge clock);
    ev <= v;
    repeat (2) @(posedge clock);
    ev <= 16'h0000;
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask : pulse

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (5000) @(posedge clock);
    fail_count++;
    print_verdict();
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    strb = 4'hF;
    ev = '0;
    sys_rst = 1'b1;
    fail_count = 0;
    n_tests = 0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    read_reg(FLAGS_OFFSET, "flags_reset", {16'h0000, FLAGS_RESET});
    read_reg(MASKS_OFFSET, "masks_reset", {16'h0000, MASKS_RESET});
    check_bit("irq_reset", 1'b0, irq);
    $display("test reset_values done");
    for (int i = 0; i < 16; i++) begin
      pulse(16'h0001 << i);
      read_reg(FLAGS_OFFSET, "flag_set", {16'h0000, 16'h0001 << i});
      check_bit("irq_unmasked", 1'b1, irq);
      bus(1'b1, FLAGS_OFFSET, {16'h0000, 16'h0001 << i});
      read_reg(FLAGS_OFFSET, "flag_cleared", 32'h0000_0000);
      check_bit("irq_cleared", 1'b0, irq);
    end
    $display("test event_map done");
    pulse(16'h8001);
    repeat (10) @(posedge clock);
    read_reg(FLAGS_OFFSET, "flags_sticky", 32'h0000_8001);
    bus(1'b1, FLAGS_OFFSET, 32'h0000_0000);
    read_reg(FLAGS_OFFSET, "flags_write_zero", 32'h0000_8001);
    bus(1'b1, FLAGS_OFFSET, 32'h0000_0001);
    read_reg(FLAGS_OFFSET, "flags_single_clear", 32'h0000_8000);
    $display("test sticky_clear done");
    bus(1'b1, MASKS_OFFSET, 32'h0000_8000);
    read_reg(MASKS_OFFSET, "masks_rw", 32'h0000_8000);
    check_bit("irq_masked", 1'b0, irq);
    bus(1'b1, MASKS_OFFSET, 32'hFFFF_7FFF);
    read_reg(MASKS_OFFSET, "masks_upper_zero", 32'h0000_7FFF);
    check_bit("irq_other_masked", 1'b1, irq);
    // upper lane only: low byte of the masks keeps its value
    strb = 4'h2;
    bus(1'b1, MASKS_OFFSET, 32'h0000_AA00);
    strb = 4'hF;
    read_reg(MASKS_OFFSET, "masks_lane", 32'h0000_AAFF);
    $display("test masking done");
    // one-cycle event that reaches the flag at the very edge of the clearing write
    @(posedge clock);
    ev <= 16'h0008;
    fork
      begin
        @(posedge clock);
        ev <= 16'h0000;
      end
      bus(1'b1, FLAGS_OFFSET, 32'h0000_8008);
    join
    read_reg(FLAGS_OFFSET, "set_wins", 32'h0000_0008);
    $display("test set_over_clear done");
    bus(1'b0, 12'h008, 32'h0000_0000);
    check_word("unmapped_read", 32'h0000_0000, rd);
    check_bit("unmapped_err", 1'b1, err);
    bus(1'b1, 12'h008, 32'hFFFF_FFFF);
    read_reg(FLAGS_OFFSET, "flags_after_stray", 32'h0000_0008);
    read_reg(MASKS_OFFSET, "masks_after_stray", 32'h0000_AAFF);
    $display("test unmapped done");
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    read_reg(FLAGS_OFFSET, "flags_rereset", 32'h0000_0000);
    read_reg(MASKS_OFFSET, "masks_rereset", 32'h0000_0000);
    check_bit("irq_rereset", 1'b0, irq);
    $display("test mid_reset done");
    print_verdict();
  end
endmodule : regulator_fault_flags_masks_tb
